// ===== logic/lid_regs.vh
// constants for the instruction decoder: opcodes, fields, reset values, bus map
// assumes inclusion by bare name from the decoder core, the only design file of the block that includes it
`ifndef LID_REGS_VH
`define LID_REGS_VH

// instruction opcodes and match masks
`define LID_OP_SET_MODE 8'h38
`define LID_MASK_FULL 8'hFF
`define LID_MASK_2B 8'hF0
`define LID_OP_2B 8'h40
`define LID_OP_CONTRAST 8'h81
`define LID_OP_DATA_LEN 8'hE8
`define LID_MASK_ICON 8'hFE
`define LID_OP_ICON 8'hA2
`define LID_MASK_PAGE 8'hF0
`define LID_OP_PAGE 8'hB0
`define LID_MASK_COL_HI 8'hF8
`define LID_OP_COL_HI 8'h10
`define LID_MASK_COL_LO 8'hF0
`define LID_OP_COL_LO 8'h00
`define LID_MASK_DISP 8'hFE
`define LID_OP_DISP 8'hAE

// field positions
`define LID_FR_MSB 7
`define LID_FR_LSB 4
`define LID_BE_MSB 3
`define LID_BE_LSB 2
`define LID_MODE_ZERO_BIT 0
`define LID_FLAG_BIT 0
`define LID_START_MSB 6
`define LID_SUB_MSB 3
`define LID_SUB_LSB 2
`define LID_PAGE_MSB 3
`define LID_COL_HI_MSB 2
`define LID_COL_LO_MSB 3

// widths and special values
`define LID_PAGE_W 5
`define LID_COL_W 7
`define LID_LINE_W 7
`define LID_RAM_AW 12
`define LID_ICON_PAGE 5'h10
`define LID_COL_STEP 7'h01
`define LID_CNT_STEP 16'h0001
`define LID_SUB_NONE 2'h0

// reset values
`define LID_RST_FR 4'h0
`define LID_RST_BE 2'h2
`define LID_RST_CTRL 3'h1

// frame frequency in Hz per frame-rate code
`define LID_HZ_0 8'h4D
`define LID_HZ_1 8'h33
`define LID_HZ_2 8'h37
`define LID_HZ_3 8'h3A
`define LID_HZ_4 8'h3F
`define LID_HZ_5 8'h43
`define LID_HZ_6 8'h44
`define LID_HZ_7 8'h46
`define LID_HZ_8 8'h49
`define LID_HZ_9 8'h4B
`define LID_HZ_A 8'h50
`define LID_HZ_B 8'h55
`define LID_HZ_C 8'h5B
`define LID_HZ_D 8'h66
`define LID_HZ_E 8'h71
`define LID_HZ_F 8'h7B

// register map, byte addresses
`define LID_REG_CTRL 8'h00
`define LID_REG_STATUS 8'h04
`define LID_REG_START 8'h08
`define LID_REG_FRAME 8'h0C
`define LID_REG_RAMADDR 8'h10
`define LID_REG_RAMDATA 8'h14
`define LID_REG_BYTECNT 8'h18
`define LID_CTRL_EN 0
`define LID_CTRL_ALLON 1
`define LID_CTRL_REV 2
`define LID_RESP_OKAY 2'h0
`define LID_RESP_SLVERR 2'h2
`define LID_ZERO32 32'h0000_0000

// decoder states
`define LID_ST_IDLE 2'h0
`define LID_ST_MODE 2'h1
`define LID_ST_START 2'h2
`define LID_ST_SKIP 2'h3

`endif

// ===== logic/lid_sync3.v
// three-stage pin synchroniser with agreement filter, one bit per lane
// assumes asynchronous inputs and a single sys_clk domain
`timescale 1ns/10ps
`default_nettype none
module lid_sync3 #(
  parameter WIDTH = 11
) (
  // clock and control
  input wire sys_clk,
  input wire rst,
  input wire sysClkEn,
  // pins in, filtered levels out
  input wire [WIDTH-1:0] pinIn,
  output reg [WIDTH-1:0] syncOut
);
  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;
  reg [WIDTH-1:0] stage3;
  integer i;

  // stage1 feeds stage2 only; a lane moves once stages two and three agree
  always @(posedge sys_clk) begin
    if (rst) begin
      stage1 <= {WIDTH{1'b0}};
      stage2 <= {WIDTH{1'b0}};
      stage3 <= {WIDTH{1'b0}};
      syncOut <= {WIDTH{1'b0}};
    end else if (sysClkEn) begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
      for (i = 0; i < WIDTH; i = i + 1) begin
        if (stage2[i] == stage3[i]) begin
          syncOut[i] <= stage3[i];
        end
      end
    end
  end
endmodule // lid_sync3
`default_nettype wire

// ===== logic/lid_display_ram.v
// display ram: one write port, one read port with registered read data
// assumes the owner keeps addresses within depth; contents have no reset
`timescale 1ns/10ps
`default_nettype none
module lid_display_ram #(
  parameter ADDR_W = 12,
  parameter DATA_W = 8
) (
  // clock
  input wire sys_clk,
  input wire sysClkEn,
  // write port
  input wire wrEn,
  input wire [ADDR_W-1:0] wrAddr,
  input wire [DATA_W-1:0] wrData,
  // read port
  input wire [ADDR_W-1:0] rdAddr,
  output reg [DATA_W-1:0] rdData
);
  reg [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  always @(posedge sys_clk) begin
    if (sysClkEn) begin
      if (wrEn) begin
        mem[wrAddr] <= wrData;
      end
      rdData <= mem[rdAddr];
    end
  end
endmodule // lid_display_ram
`default_nettype wire

// ===== logic/lid_decoder_core.v
// instruction and display-data decoder of a gray-scale dot-matrix controller
// assumes host byte pins are asynchronous and held stable around the strobe edge
//
// Contract
// RL1 - set mode second byte: frame code bits 7..4, booster bits 3..2, bit 0 zero
// RL2 - frame code maps to frame frequency, 0000 is 77 Hz up to 1111 at 123 Hz
// RL3 - booster code 00..11 selects level 1..4, code 10 recommended
// RL4 - data-select write byte stored at current page and column
// RL5 - column address increases by one after every display-data access
// RL6 - column wraps from last column to 0 on the same page
// RL7 - icon command sets icon flag from bit 0; cleared after reset
// RL8 - icon flag set forces page 16; cleared flag disables icon display
// RL9 - host issues icon enable before writing icon data
// RL10 - page command loads bits 3..0, pages 0 to 15, never page 16
// RL11 - page change moves only the access pointer, not the shown image
// RL12 - column address split: upper command bits 6..4, lower command bits 3..0
// RL13 - display on/off bit 0: one on, zero off
// RL14 - display off overrides force-all-on and reverse display
// RL15 - start line second byte low seven bits pick the first shown line
// RL16 - start line shown on top panel row, following lines on following rows
// RL17 - select low means instruction, select high means display data
// RL18 - byte after a two-byte opcode is its parameter, not a new opcode
//
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "lid_regs.vh"
module lid_decoder_core (
  // clock, reset, enable
  input wire sys_clk,
  input wire rst,
  input wire sysClkEn,
  // host byte pins
  input wire [7:0] pinDataByte,
  input wire pinCmdDataSelect,
  input wire pinReadNotWrite,
  input wire pinStrobe,
  // panel timing logic
  input wire [6:0] scanRow,
  // panel configuration out
  output reg [3:0] frameRateCode,
  output reg [1:0] boosterLevelCode,
  output reg [7:0] frameHz,
  output reg iconEnable,
  output reg panelDisplayOn,
  output reg panelBlank,
  output reg panelAllOn,
  output reg panelReverse,
  output reg [6:0] startLine,
  output reg [6:0] scanLine,
  output reg [4:0] pageAddr,
  output reg [6:0] columnAddr,
  // axi4-lite write channels
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read channels
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  wire [10:0] syncBus;
  wire [7:0] hostByte;
  wire hostSel;
  wire hostRnw;
  wire hostStrobe;
  reg strobeLast;
  wire byteEvent;
  reg [1:0] state;
  reg [2:0] ctrl;
  reg [15:0] byteCount;
  reg ramWrEn;
  reg [`LID_RAM_AW-1:0] ramWrAddr;
  reg [7:0] ramWrData;
  reg [`LID_RAM_AW-1:0] ramRdAddr;
  wire [7:0] ramRdData;
  reg [7:0] awAddrHeld;
  reg awHeld;
  reg [31:0] wDataHeld;
  reg [3:0] wStrbHeld;
  reg wHeld;
  reg [7:0] arAddrHeld;
  reg rdPending;
  reg [7:0] next_frameHz;

  lid_sync3 #(
    .WIDTH(11)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .sysClkEn(sysClkEn),
    .pinIn({pinStrobe, pinReadNotWrite, pinCmdDataSelect, pinDataByte}),
    .syncOut(syncBus)
  );

  assign hostByte = syncBus[7:0];
  assign hostSel = syncBus[8];
  assign hostRnw = syncBus[9];
  assign hostStrobe = syncBus[10];
  // bytes are ignored while software holds the stream disabled
  assign byteEvent = hostStrobe & ~strobeLast & ctrl[`LID_CTRL_EN];

  lid_display_ram #(
    .ADDR_W(`LID_RAM_AW),
    .DATA_W(8)
  ) u_ram (
    .sys_clk(sys_clk),
    .sysClkEn(sysClkEn),
    .wrEn(ramWrEn),
    .wrAddr(ramWrAddr),
    .wrData(ramWrData),
    .rdAddr(ramRdAddr),
    .rdData(ramRdData)
  );

  // frame frequency lookup in hertz
  always @* begin
    case (frameRateCode) // RL2
      4'h0: next_frameHz = `LID_HZ_0;
      4'h1: next_frameHz = `LID_HZ_1;
      4'h2: next_frameHz = `LID_HZ_2;
      4'h3: next_frameHz = `LID_HZ_3;
      4'h4: next_frameHz = `LID_HZ_4;
      4'h5: next_frameHz = `LID_HZ_5;
      4'h6: next_frameHz = `LID_HZ_6;
      4'h7: next_frameHz = `LID_HZ_7;
      4'h8: next_frameHz = `LID_HZ_8;
      4'h9: next_frameHz = `LID_HZ_9;
      4'hA: next_frameHz = `LID_HZ_A;
      4'hB: next_frameHz = `LID_HZ_B;
      4'hC: next_frameHz = `LID_HZ_C;
      4'hD: next_frameHz = `LID_HZ_D;
      4'hE: next_frameHz = `LID_HZ_E;
      default: next_frameHz = `LID_HZ_F;
    endcase
  end

  // byte decoder
  always @(posedge sys_clk) begin
    if (rst) begin
      strobeLast <= 1'b0;
      state <= `LID_ST_IDLE;
      frameRateCode <= `LID_RST_FR;
      boosterLevelCode <= `LID_RST_BE;
      iconEnable <= 1'b0; // RL7
      panelDisplayOn <= 1'b0;
      startLine <= {`LID_LINE_W{1'b0}};
      pageAddr <= {`LID_PAGE_W{1'b0}};
      columnAddr <= {`LID_COL_W{1'b0}};
      byteCount <= 16'h0000;
      ramWrEn <= 1'b0;
      ramWrAddr <= {`LID_RAM_AW{1'b0}};
      ramWrData <= 8'h00;
    end else if (sysClkEn) begin
      strobeLast <= hostStrobe;
      ramWrEn <= 1'b0;
      if (byteEvent) begin
        byteCount <= byteCount + `LID_CNT_STEP;
        if (hostSel) begin // RL17
          if (!hostRnw) begin
            ramWrEn <= 1'b1; // RL4
            ramWrAddr <= {pageAddr, columnAddr}; // RL4
            ramWrData <= hostByte;
          end
          // seven-bit add rolls 127 over to 0 and leaves the page alone
          columnAddr <= columnAddr + `LID_COL_STEP; // RL5 RL6
        end else if (!hostRnw) begin
          case (state)
            `LID_ST_MODE: begin
              if (hostByte[`LID_MODE_ZERO_BIT] == 1'b0) begin // RL1
                frameRateCode <= hostByte[`LID_FR_MSB:`LID_FR_LSB]; // RL1
                boosterLevelCode <= hostByte[`LID_BE_MSB:`LID_BE_LSB]; // RL1 RL3
              end
              state <= `LID_ST_IDLE;
            end
            `LID_ST_START: begin
              startLine <= hostByte[`LID_START_MSB:0]; // RL15
              state <= `LID_ST_IDLE;
            end
            `LID_ST_SKIP: begin
              state <= `LID_ST_IDLE; // RL18
            end
            default: begin
              if (hostByte == `LID_OP_SET_MODE) begin
                state <= `LID_ST_MODE; // RL18
              end else if ((hostByte & `LID_MASK_2B) == `LID_OP_2B) begin
                if (hostByte[`LID_SUB_MSB:`LID_SUB_LSB] == `LID_SUB_NONE) begin
                  state <= `LID_ST_START; // RL18
                end else begin
                  state <= `LID_ST_SKIP; // RL18
                end
              end else if (hostByte == `LID_OP_CONTRAST || hostByte == `LID_OP_DATA_LEN) begin
                state <= `LID_ST_SKIP; // RL18
              end else if ((hostByte & `LID_MASK_ICON) == `LID_OP_ICON) begin
                iconEnable <= hostByte[`LID_FLAG_BIT]; // RL7
                if (hostByte[`LID_FLAG_BIT]) begin
                  pageAddr <= `LID_ICON_PAGE; // RL8
                end
              end else if ((hostByte & `LID_MASK_PAGE) == `LID_OP_PAGE) begin
                // top page bit forced low, so page 16 is unreachable here
                pageAddr <= {1'b0, hostByte[`LID_PAGE_MSB:0]}; // RL10 RL11
              end else if ((hostByte & `LID_MASK_COL_HI) == `LID_OP_COL_HI) begin
                columnAddr[`LID_COL_W-1:`LID_COL_LO_MSB+1] <=
                  hostByte[`LID_COL_HI_MSB:0]; // RL12
              end else if ((hostByte & `LID_MASK_COL_LO) == `LID_OP_COL_LO) begin
                columnAddr[`LID_COL_LO_MSB:0] <= hostByte[`LID_COL_LO_MSB:0]; // RL12
              end else if ((hostByte & `LID_MASK_DISP) == `LID_OP_DISP) begin
                panelDisplayOn <= hostByte[`LID_FLAG_BIT]; // RL13
              end
            end
          endcase
        end
      end
    end
  end

  // panel-facing outputs, registered
  always @(posedge sys_clk) begin
    if (rst) begin
      frameHz <= `LID_HZ_0;
      panelBlank <= 1'b1;
      panelAllOn <= 1'b0;
      panelReverse <= 1'b0;
      scanLine <= {`LID_LINE_W{1'b0}};
    end else if (sysClkEn) begin
      frameHz <= next_frameHz; // RL2
      panelBlank <= ~panelDisplayOn; // RL13 RL14
      panelAllOn <= panelDisplayOn & ctrl[`LID_CTRL_ALLON]; // RL14
      // force-all-on also outranks reverse
      panelReverse <= panelDisplayOn & ~ctrl[`LID_CTRL_ALLON] & ctrl[`LID_CTRL_REV]; // RL14
      // row 0 shows the start line; wraps modulo 128
      scanLine <= startLine + scanRow; // RL16
    end
  end

  // axi4-lite write side: address and data taken in either order
  always @(posedge sys_clk) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `LID_RESP_OKAY;
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddrHeld <= 8'h00;
      wDataHeld <= `LID_ZERO32;
      wStrbHeld <= 4'h0;
      ctrl <= `LID_RST_CTRL;
      ramRdAddr <= {`LID_RAM_AW{1'b0}};
    end else if (sysClkEn) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddrHeld <= s_axi_awaddr;
        awHeld <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wDataHeld <= s_axi_wdata;
        wStrbHeld <= s_axi_wstrb;
        wHeld <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (awHeld && wHeld && !s_axi_bvalid) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `LID_RESP_OKAY;
        case (awAddrHeld)
          `LID_REG_CTRL: begin
            if (wStrbHeld[0]) begin
              ctrl <= wDataHeld[2:0];
            end
          end
          `LID_REG_RAMADDR: begin
            if (wStrbHeld[0]) begin
              ramRdAddr[7:0] <= wDataHeld[7:0];
            end
            if (wStrbHeld[1]) begin
              ramRdAddr[`LID_RAM_AW-1:8] <= wDataHeld[`LID_RAM_AW-1:8];
            end
          end
          `LID_REG_STATUS, `LID_REG_START, `LID_REG_FRAME,
          `LID_REG_RAMDATA, `LID_REG_BYTECNT: begin
            s_axi_bresp <= `LID_RESP_OKAY;
          end
          default: begin
            s_axi_bresp <= `LID_RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // axi4-lite read side: one wait cycle lets the ram read settle
  always @(posedge sys_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `LID_ZERO32;
      s_axi_rresp <= `LID_RESP_OKAY;
      arAddrHeld <= 8'h00;
      rdPending <= 1'b0;
    end else if (sysClkEn) begin
      if (s_axi_arvalid && s_axi_arready) begin
        arAddrHeld <= s_axi_araddr;
        s_axi_arready <= 1'b0;
        rdPending <= 1'b1;
      end
      if (rdPending) begin
        rdPending <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `LID_RESP_OKAY;
        s_axi_rdata <= `LID_ZERO32;
        case (arAddrHeld)
          `LID_REG_CTRL: s_axi_rdata[2:0] <= ctrl;
          `LID_REG_STATUS: s_axi_rdata[24:0] <= {columnAddr, 3'h0, pageAddr, 2'h0,
            panelDisplayOn, iconEnable, boosterLevelCode, frameRateCode};
          `LID_REG_START: s_axi_rdata[6:0] <= startLine;
          `LID_REG_FRAME: s_axi_rdata[7:0] <= frameHz;
          `LID_REG_RAMADDR: s_axi_rdata[`LID_RAM_AW-1:0] <= ramRdAddr;
          `LID_REG_RAMDATA: s_axi_rdata[7:0] <= ramRdData;
          `LID_REG_BYTECNT: s_axi_rdata[15:0] <= byteCount;
          default: s_axi_rresp <= `LID_RESP_SLVERR;
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule // lid_decoder_core
`default_nettype wire

// ===== tb/lid_decoder_core_chk.sv
// checker for the decoder's panel outputs and bus answer timing
// assumes sysClkEn held high, so every sys_clk edge is an active one
`timescale 1ns/10ps
`default_nettype none
module lid_decoder_core_chk (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // panel side
  input wire logic [6:0] scanRow,
  input wire logic [3:0] frameRateCode,
  input wire logic [7:0] frameHz,
  input wire logic iconEnable,
  input wire logic panelDisplayOn,
  input wire logic panelBlank,
  input wire logic panelAllOn,
  input wire logic panelReverse,
  input wire logic [6:0] startLine,
  input wire logic [6:0] scanLine,
  input wire logic [4:0] pageAddr,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  localparam logic [127:0] HZ = 128'h7B71_665B_5550_4B49_4644_433F_3A37_334D;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // outputs lag their state by one edge, so the edge right after reset is skipped
  a_blank_tracks_on:
    assert property (!$past(rst) |-> panelBlank == !$past(panelDisplayOn))
    else $error("blank does not follow display state");
  a_hz_from_code:
    assert property (!$past(rst) |-> frameHz == HZ[$past(frameRateCode) * 8 +: 8])
    else $error("frame frequency does not match code");
  a_off_wins:
    assert property ((panelAllOn || panelReverse) |-> $past(panelDisplayOn))
    else $error("force or reverse active while display off");
  a_allon_over_rev:
    assert property (!(panelAllOn && panelReverse))
    else $error("force all on and reverse both active");
  a_page_limit:
    assert property (pageAddr <= 5'h10)
    else $error("page beyond icon page");
  a_icon_page_only:
    assert property (($changed(pageAddr) && pageAddr == 5'h10) |-> iconEnable)
    else $error("page 16 reached without icon enable");
  a_icon_reset:
    assert property ($past(rst) |-> !iconEnable)
    else $error("icon enable set after reset");
  a_scan_sum:
    assert property (!$past(rst) |-> scanLine == 7'($past(startLine) + $past(scanRow)))
    else $error("scan line not offset by start line");
  a_write_answer:
    assert property (s_wr_take |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_answer:
    assert property (s_rd_take |-> ##2 s_axi_rvalid)
    else $error("read data not two cycles after address");
endmodule // lid_decoder_core_chk
bind lid_decoder_core lid_decoder_core_chk chk_u (.sys_clk(sys_clk), .rst(rst),
  .scanRow(scanRow), .frameRateCode(frameRateCode), .frameHz(frameHz),
  .iconEnable(iconEnable), .panelDisplayOn(panelDisplayOn), .panelBlank(panelBlank),
  .panelAllOn(panelAllOn), .panelReverse(panelReverse), .startLine(startLine),
  .scanLine(scanLine), .pageAddr(pageAddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid));
`default_nettype wire

// ===== tb/lid_host_model.sv
// host processor model driving the byte pins of the decoder
// assumes the caller waits for each send to finish before the next
`timescale 1ns/10ps
`default_nettype none
module lid_host_model (
  // clock
  input wire logic sys_clk,
  // host byte pins
  output logic [7:0] pinDataByte,
  output logic pinCmdDataSelect,
  output logic pinReadNotWrite,
  output logic pinStrobe
);
  initial begin
    pinDataByte = 8'h00;
    pinCmdDataSelect = 1'b0;
    pinReadNotWrite = 1'b0;
    pinStrobe = 1'b0;
  end
  // margins exceed the three-flop synchroniser so the byte is never split
  task automatic send(input logic sel, input logic rnw, input logic [7:0] b);
    @(posedge sys_clk);
    pinDataByte <= b;
    pinCmdDataSelect <= sel;
    pinReadNotWrite <= rnw;
    repeat (5) @(posedge sys_clk);
    pinStrobe <= 1'b1;
    repeat (6) @(posedge sys_clk);
    pinStrobe <= 1'b0;
    repeat (5) @(posedge sys_clk);
    // hold over: the lines no longer carry the byte
    pinDataByte <= ~b;
  endtask
endmodule // lid_host_model
`default_nettype wire

// ===== tb/lcd_instruction_decoder_core_test.sv
// self-checking bench: host model on the pins, bus master on the registers
// assumes sysClkEn tied high and a reference decoder kept in integers here
`timescale 1ns/10ps
`default_nettype none
module lcd_instruction_decoder_core_test;
  localparam logic [127:0] HZ = 128'h7B71_665B_5550_4B49_4644_433F_3A37_334D;
  logic sys_clk, rst, sysClkEn, pinCmdDataSelect, pinReadNotWrite, pinStrobe;
  logic [7:0] pinDataByte, frameHz, awaddr, araddr;
  logic [6:0] scanRow, startLine, scanLine, columnAddr;
  logic [3:0] frameRateCode, wstrb;
  logic [1:0] boosterLevelCode, bresp, rresp;
  logic iconEnable, panelDisplayOn, panelBlank, panelAllOn, panelReverse;
  logic [4:0] pageAddr;
  logic [31:0] wdata, rdata, d;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] ram [0:4095];
  int fails, comparisons, fr, be, ic, dn, pg, col, st, w, en, la, seed, i, nb;
  lid_host_model hm_u (.sys_clk(sys_clk), .pinDataByte(pinDataByte),
    .pinCmdDataSelect(pinCmdDataSelect), .pinReadNotWrite(pinReadNotWrite),
    .pinStrobe(pinStrobe));
  lid_decoder_core dut_u (.sys_clk(sys_clk), .rst(rst), .sysClkEn(sysClkEn),
    .pinDataByte(pinDataByte), .pinCmdDataSelect(pinCmdDataSelect),
    .pinReadNotWrite(pinReadNotWrite), .pinStrobe(pinStrobe), .scanRow(scanRow),
    .frameRateCode(frameRateCode), .boosterLevelCode(boosterLevelCode), .frameHz(frameHz),
    .iconEnable(iconEnable), .panelDisplayOn(panelDisplayOn), .panelBlank(panelBlank),
    .panelAllOn(panelAllOn), .panelReverse(panelReverse), .startLine(startLine),
    .scanLine(scanLine), .pageAddr(pageAddr), .columnAddr(columnAddr),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // time limit is 50000 cycles, far above the whole run
  initial begin
    #200000;
    fails++;
    end_sim();
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    chk("bresp", bresp, er);
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    v = rdata;
    rready <= 1'b0;
    chk("rresp", rresp, er);
  endtask
  // reference decoder updated alongside every byte sent while the stream is enabled
  task automatic hb(input logic sel, input logic rnw, input logic [7:0] b);
    hm_u.send(sel, rnw, b);
    if (en == 0) return;
    nb++;
    if (sel) begin
      la = pg * 128 + col;
      if (!rnw) ram[la] = b;
      col = (col + 1) % 128;
    end else if (!rnw) begin
      if (w == 1) begin
        if (!b[0]) begin
          fr = b[7:4];
          be = b[3:2];
        end
        w = 0;
      end else if (w == 2) begin
        st = b[6:0];
        w = 0;
      end else if (w == 3) w = 0;
      else if (b == 8'h38) w = 1;
      else if (b[7:2] == 6'h10) w = 2;
      else if (b[7:4] == 4'h4 || b == 8'h81 || b == 8'hE8) w = 3;
      else if (b[7:1] == 7'h51) begin
        ic = b[0];
        if (b[0]) pg = 16;
      end else if (b[7:4] == 4'hB) pg = b[3:0];
      else if (b[7:3] == 5'h02) col = (b[2:0] << 4) | (col & 15);
      else if (b[7:4] == 4'h0) col = (col & 8'h70) | b[3:0];
      else if (b[7:1] == 7'h57) dn = b[0];
    end
  endtask
  task automatic check_all();
    axr(8'h04, d, 2'h0);
    chk("status", d, (col << 18) | (pg << 10) | (dn << 7) | (ic << 6) | (be << 4) | fr);
    axr(8'h0C, d, 2'h0);
    chk("frame", d, HZ[fr * 8 +: 8]);
    axr(8'h08, d, 2'h0);
    chk("start", d, st);
    axr(8'h18, d, 2'h0);
    chk("count", d, nb);
    chk("ports", {columnAddr, pageAddr, startLine, boosterLevelCode},
      {7'(col), 5'(pg), 7'(st), 2'(be)});
  endtask
  task automatic ram_chk(input int a);
    axw(8'h10, a, 2'h0);
    axr(8'h14, d, 2'h0);
    chk("ram", d, ram[a]);
  endtask
  initial begin
    {rst, sysClkEn, awvalid, wvalid, bready, arvalid, rready} = 7'h60;
    {awaddr, araddr, wdata, wstrb, scanRow} = {48'h0, 4'hF, 7'h00};
    {fails, comparisons, fr, be, ic, dn, pg, col, st, w, en} = {32'd0, 32'd0, 32'd0, 32'd2,
      32'd0, 32'd0, 32'd0, 32'd0, 32'd0, 32'd0, 32'd1};
    seed = 43529;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    check_all();
    chk("icon", iconEnable, 1'b0);
    chk("blank", panelBlank, 1'b1);
    axr(8'h00, d, 2'h0);
    chk("ctrl", d, 32'h0000_0001);
    axr(8'h1C, d, 2'h2);
    chk("unmapped", d, 32'h0000_0000);
    axw(8'h1C, 32'h0000_0000, 2'h2);
    $display("test reset done");
    for (i = 0; i < 16; i++) begin
      hb(1'b0, 1'b0, 8'h38);
      hb(1'b0, 1'b0, {i[3:0], i[1:0], 2'b00});
      check_all();
    end
    hb(1'b0, 1'b0, 8'h38);
    hb(1'b0, 1'b0, 8'h71);
    check_all();
    $display("test set mode done");
    hb(1'b0, 1'b0, 8'hB3);
    hb(1'b0, 1'b0, 8'h12);
    hb(1'b0, 1'b0, 8'h05);
    hb(1'b1, 1'b0, 8'h5A);
    check_all();
    ram_chk(la);
    hb(1'b0, 1'b0, 8'h17);
    hb(1'b0, 1'b0, 8'h0E);
    for (i = 0; i < 3; i++) hb(1'b1, 1'b0, 8'($random(seed)));
    check_all();
    for (i = 0; i < 3; i++) ram_chk(3 * 128 + (126 + i) % 128);
    $display("test addressing done");
    hb(1'b0, 1'b0, 8'hBF);
    check_all();
    hb(1'b0, 1'b0, 8'hA3);
    hb(1'b1, 1'b0, 8'($random(seed)));
    check_all();
    ram_chk(la);
    hb(1'b0, 1'b0, 8'hA2);
    check_all();
    hb(1'b0, 1'b0, 8'h40);
    hb(1'b1, 1'b0, 8'hC3);
    hb(1'b0, 1'b0, 8'hB5);
    hb(1'b0, 1'b0, 8'h44);
    hb(1'b0, 1'b0, 8'hB7);
    check_all();
    ram_chk(la);
    $display("test icon and parameters done");
    axw(8'h00, 32'h0000_0007, 2'h0);
    hb(1'b0, 1'b0, 8'hAF);
    chk("allon", {panelAllOn, panelReverse, panelBlank}, 3'b100);
    axw(8'h00, 32'h0000_0005, 2'h0);
    repeat (4) @(posedge sys_clk);
    chk("reverse", {panelAllOn, panelReverse, panelBlank}, 3'b010);
    hb(1'b0, 1'b0, 8'hAE);
    chk("off", {panelAllOn, panelReverse, panelBlank}, 3'b001);
    check_all();
    $display("test display done");
    hb(1'b0, 1'b0, 8'h40);
    hb(1'b0, 1'b0, 8'h7F);
    for (i = 0; i < 4; i++) begin
      scanRow <= 7'($random(seed));
      repeat (3) @(posedge sys_clk);
      chk("scan", scanLine, 7'(st + scanRow));
    end
    axw(8'h00, 32'h0000_0000, 2'h0);
    en = 0;
    hb(1'b0, 1'b0, 8'hBA);
    axw(8'h00, 32'h0000_0001, 2'h0);
    en = 1;
    hb(1'b1, 1'b1, 8'h00);
    hb(1'b0, 1'b1, 8'hB4);
    check_all();
    $display("test start line and reads done");
    end_sim();
  end
endmodule // lcd_instruction_decoder_core_test
`default_nettype wire
